// file: core/fmp_consts.svh
// register offsets, field positions, reset values and mapping constants
`ifndef FMP_CONSTS_SVH
`define FMP_CONSTS_SVH
`define FMP_IDX_CLKDIV 4'h0
`define FMP_IDX_SEC 4'h1
`define FMP_IDX_RSVD_A 4'h2
`define FMP_IDX_CNFG 4'h3
`define FMP_IDX_PROT 4'h4
`define FMP_IDX_STAT 4'h5
`define FMP_IDX_CMD 4'h6
`define FMP_IDX_RSVD_B 4'h7
`define FMP_IDX_TADDR_HI 4'h8
`define FMP_IDX_TADDR_LO 4'h9
`define FMP_IDX_TDATA_HI 4'hA
`define FMP_IDX_TDATA_LO 4'hB
`define FMP_IDX_RSVD_C 4'hC
`define FMP_IDX_RSVD_D 4'hD
`define FMP_IDX_RSVD_E 4'hE
`define FMP_IDX_RSVD_F 4'hF
`define FMP_BIT_LOADED 7
`define FMP_BIT_PRESCALE 6
`define FMP_BIT_KEY_WRITE_ACCESS 5
`define FMP_BIT_POPEN 7
`define FMP_BIT_HDIS 5
`define FMP_BIT_LDIS 2
`define FMP_BIT_PROTECT_VIOLATION_FLAG 5
`define FMP_BIT_ACCESS_ERROR_FLAG 4
`define FMP_CNFG_WMASK 8'hC0
`define FMP_CMD_WMASK 8'h65
`define FMP_KEY_ENABLED 2'h2
`define FMP_RST_BYTE 8'h00
`define FMP_PRE_LAST 3'h7
`define FMP_PAGE_LOW 8'h3E
`define FMP_PAGE_HIGH 8'h3F
`define FMP_PAGE_BASE 6'h0F
`define FMP_WIN_LOW 2'h1
`define FMP_WIN_PAGED 2'h2
`define FMP_WIN_HIGH 2'h3
`define FMP_LOW_BASE 14'h0400
`define FMP_HIGH_BASE 14'h0800
`define FMP_KEY_FIRST 16'hFF00
`define FMP_KEY_LAST 16'hFF07
`define FMP_CFG_PROT 16'hFF0D
`define FMP_CFG_SEC 16'hFF0F
`define FMP_HTRANS_NONSEQ 2'h2
`endif

// file: core/fmp_pkg.sv
// types of the flash map, protection and divider front end
package fmp_pkg;
    typedef struct packed {
        logic [7:0] clkdiv;
        logic [7:0] sec;
        logic [7:0] cnfg;
        logic [7:0] prot;
        logic [1:0] err;
        logic [7:0] cmd;
        logic cfg_done;
        logic w_pend;
        logic [3:0] w_idx;
        logic [31:0] rdata;
        logic ready;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic [2:0] pre_cnt;
        logic [5:0] div_cnt;
        logic ftick;
        logic cmd_go;
        logic [15:0] arr_addr;
        logic arr_hit;
        logic arr_prot;
        logic key_area;
        logic cfg_area;
    } fmp_state_t;
endpackage

// file: core/fmp_top.sv
// flash map decode, protection regions, register window and clock divider
// Behaviour
// - array reads answered for cpu addresses 0x4000 to 0xFFFF, three windows
// - window 0x8000-0xBFFF maps the page named by page select
// - page select 0x3C..0x3F picks array pages 0x0000..0xC000
// - fixed windows map to pages 0x3E and 0x3F, also seen paged
// - low region from array start, ends 0x43FF/0x47FF/0x4FFF/0x5FFF
// - high region down from array end, starts 0xF800/0xF000/0xE000/0xC000
// - same regions apply when pages 0x3E/0x3F are reached paged
// - remaining addresses protectable so whole array can be locked
// - backdoor key lives at array addresses 0xFF00-0xFF07
// - default protection comes from configuration byte 0xFF0D
// - security and options come from configuration byte 0xFF0F
// - sixteen byte registers decoded at word offsets 0x00 to 0x3C
// - divider readable; bits 6-0 take first write only; bit 7 unwritable
// - loaded flag cleared by reset, set by first divider write
// - prescale bit set divides oscillator by 8 before divider
// - overall divide ratio reaches at most 512
// - factory test registers read zero and ignore writes
// - security register loaded at reset, readable, never writable
// - protection register loaded at reset from byte 0xFF0D
// - key access bit writable only while backdoor enable is enabled
// - backdoor enable value 10 is enabled, others disabled
`timescale 1ns/1ps
`include "fmp_consts.svh"

module fmp_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic osc_clk,
    input wire logic [7:0] page_select,
    input wire logic acc_valid,
    input wire logic [15:0] acc_addr,
    input wire logic [7:0] cfg_prot_byte,
    input wire logic [7:0] cfg_sec_byte,
    input wire logic buffer_empty_flag,
    input wire logic all_done_flag,
    input wire logic viol_event,
    input wire logic err_event,
    output logic [15:0] arr_addr,
    output logic arr_hit,
    output logic arr_protected,
    output logic key_area,
    output logic cfg_area,
    output logic flash_tick,
    output logic cmd_start,
    output logic [7:0] operation_command,
    output logic [7:0] interrupt_and_key_config,
    output logic [7:0] security_state
);
    import fmp_pkg::*;

    fmp_state_t st_reg;
    fmp_state_t st_next;
    logic addr_ph;
    logic [3:0] a_idx;
    logic [1:0] win;
    logic [7:0] page;
    logic [7:0] wbyte;
    logic osc_edge;
    logic pre_edge;

    // ****************************************
    // helpers
    // ****************************************
    // page reached through cpu window, zero when outside the array
    function automatic logic [7:0] page_of(input logic [1:0] w, input logic [7:0] ps);
        logic [7:0] p;
        p = 8'h00;
        unique case (w)
            `FMP_WIN_LOW: p = `FMP_PAGE_LOW;
            `FMP_WIN_HIGH: p = `FMP_PAGE_HIGH;
            `FMP_WIN_PAGED: p = (ps[7:2] == `FMP_PAGE_BASE) ? ps : 8'h00;
            2'h0: p = 8'h00;
        endcase
        return p;
    endfunction

    // program or erase protection for one page offset
    function automatic logic prot_of(input logic [7:0] p, input logic [13:0] off,
                                     input logic [7:0] pr);
        logic lo;
        logic hi;
        lo = (p == `FMP_PAGE_LOW) && !pr[`FMP_BIT_LDIS]
             && (off < (`FMP_LOW_BASE << pr[1:0]));
        hi = (p == `FMP_PAGE_HIGH) && !pr[`FMP_BIT_HDIS]
             && (off >= 14'((15'h4000 - (15'(`FMP_HIGH_BASE) << pr[4:3]))));
        return pr[`FMP_BIT_POPEN] ? (lo || hi) : 1'b1;
    endfunction

    // register readback
    function automatic logic [7:0] read_of(input logic [3:0] i, input fmp_state_t s,
                                           input logic be, input logic cd);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            `FMP_IDX_CLKDIV: v = s.clkdiv;
            `FMP_IDX_SEC: v = s.sec;
            `FMP_IDX_CNFG: v = s.cnfg;
            `FMP_IDX_PROT: v = s.prot;
            `FMP_IDX_STAT: v = {be, cd, s.err, 4'h0};
            `FMP_IDX_CMD: v = s.cmd;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign addr_ph = hsel && hready && (htrans == `FMP_HTRANS_NONSEQ);
    assign a_idx = haddr[5:2];
    assign win = acc_addr[15:14];
    assign page = page_of(win, page_select);
    assign wbyte = hwdata[7:0];
    assign osc_edge = st_reg.osc_s2 && !st_reg.osc_s3;
    assign pre_edge = osc_edge
        && (!st_reg.clkdiv[`FMP_BIT_PRESCALE] || st_reg.pre_cnt == `FMP_PRE_LAST);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.cmd_go = 1'b0;
        st_next.ftick = 1'b0;
        st_next.ready = 1'b1;
        st_next.osc_s1 = osc_clk;
        st_next.osc_s2 = st_reg.osc_s1;
        st_next.osc_s3 = st_reg.osc_s2;
        // config bytes caught after reset release
        if (!st_reg.cfg_done) begin
            st_next.cfg_done = 1'b1;
            st_next.sec = cfg_sec_byte;
            st_next.prot = cfg_prot_byte;
        end
        // sticky errors, set wins over clear
        if (st_reg.w_pend && st_reg.w_idx == `FMP_IDX_STAT) begin
            st_next.err = st_reg.err & ~wbyte[`FMP_BIT_PROTECT_VIOLATION_FLAG:`FMP_BIT_ACCESS_ERROR_FLAG];
        end
        if (viol_event) begin
            st_next.err[1] = 1'b1;
        end
        if (err_event) begin
            st_next.err[0] = 1'b1;
        end
        // data phase write, test registers ignore writes
        if (st_reg.w_pend) begin
            unique case (st_reg.w_idx)
                `FMP_IDX_CLKDIV: begin
                    if (!st_reg.clkdiv[`FMP_BIT_LOADED]) begin
                        st_next.clkdiv = {1'b1, wbyte[6:0]};
                    end
                end
                `FMP_IDX_CNFG: begin
                    st_next.cnfg = (wbyte & `FMP_CNFG_WMASK) | (st_reg.cnfg & 8'h20);
                    // key access gated by enable field
                    if (st_reg.sec[7:6] == `FMP_KEY_ENABLED) begin
                        st_next.cnfg[`FMP_BIT_KEY_WRITE_ACCESS] = wbyte[`FMP_BIT_KEY_WRITE_ACCESS];
                    end
                end
                `FMP_IDX_PROT: begin
                    st_next.prot[`FMP_BIT_POPEN] = st_reg.prot[7] & wbyte[7];
                    st_next.prot[6] = st_reg.prot[6];
                    st_next.prot[`FMP_BIT_HDIS] = st_reg.prot[5] & wbyte[5];
                    st_next.prot[`FMP_BIT_LDIS] = st_reg.prot[2] & wbyte[2];
                    if (st_reg.prot[`FMP_BIT_HDIS]) begin
                        st_next.prot[4:3] = wbyte[4:3];
                    end
                    if (st_reg.prot[`FMP_BIT_LDIS]) begin
                        st_next.prot[1:0] = wbyte[1:0];
                    end
                end
                `FMP_IDX_CMD: begin
                    if (st_reg.clkdiv[`FMP_BIT_LOADED]) begin
                        st_next.cmd = wbyte & `FMP_CMD_WMASK;
                        st_next.cmd_go = 1'b1;
                    end else begin
                        st_next.err[0] = 1'b1;
                    end
                end
                default: st_next.w_pend = 1'b0;
            endcase
        end
        st_next.w_pend = addr_ph && hwrite && (haddr[31:6] == 26'h0);
        st_next.w_idx = a_idx;
        if (addr_ph && !hwrite && (haddr[31:6] == 26'h0)) begin
            st_next.rdata = {24'h0,
                read_of(a_idx, st_next, buffer_empty_flag, all_done_flag)};
        end else if (addr_ph) begin
            st_next.rdata = 32'h0;
        end
        // prescaler and divider, idle until loaded
        if (st_reg.clkdiv[`FMP_BIT_LOADED] && osc_edge) begin
            st_next.pre_cnt = 3'(st_reg.pre_cnt + 3'h1);
            if (pre_edge) begin
                if (st_reg.div_cnt == st_reg.clkdiv[5:0]) begin
                    st_next.div_cnt = 6'h00;
                    st_next.ftick = 1'b1;
                end else begin
                    st_next.div_cnt = 6'(st_reg.div_cnt + 6'h01);
                end
            end
        end
        st_next.arr_hit = acc_valid && (page != 8'h00);
        st_next.arr_addr = {page[1:0], acc_addr[13:0]};
        st_next.arr_prot = acc_valid && (page != 8'h00)
            && prot_of(page, acc_addr[13:0], st_reg.prot);
        st_next.key_area = acc_valid && (page == `FMP_PAGE_HIGH)
            && ({2'h3, acc_addr[13:0]} >= `FMP_KEY_FIRST)
            && ({2'h3, acc_addr[13:0]} <= `FMP_KEY_LAST);
        st_next.cfg_area = acc_valid && (page == `FMP_PAGE_HIGH)
            && (({2'h3, acc_addr[13:0]} == `FMP_CFG_PROT)
            || ({2'h3, acc_addr[13:0]} == `FMP_CFG_SEC));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hrdata = st_reg.rdata;
    assign hreadyout = st_reg.ready;
    assign hresp = 1'b0;
    assign arr_addr = st_reg.arr_addr;
    assign arr_hit = st_reg.arr_hit;
    assign arr_protected = st_reg.arr_prot;
    assign key_area = st_reg.key_area;
    assign cfg_area = st_reg.cfg_area;
    assign flash_tick = st_reg.ftick;
    assign cmd_start = st_reg.cmd_go;
    assign operation_command = st_reg.cmd;
    assign interrupt_and_key_config = st_reg.cnfg;
    assign security_state = st_reg.sec;

    // ****************************************
    // checks
    // ****************************************
    a_div_write_once: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.clkdiv[7] |=> st_reg.clkdiv[6:0] == $past(st_reg.clkdiv[6:0]))
        else $error("divider field changed after first write");
    a_div_loaded_set: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.w_pend && st_reg.w_idx == 4'h0 |=> st_reg.clkdiv[7])
        else $error("loaded flag not set by divider write");
    a_sec_read_only: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.cfg_done |=> $stable(st_reg.sec))
        else $error("security register changed after load");
    a_key_acc_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_reg.cnfg[5]) |-> $past(st_reg.sec[7:6]) == 2'h2)
        else $error("key access set while backdoor disabled");
    a_cmd_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.cmd_go |-> st_reg.clkdiv[7])
        else $error("command started before divider loaded");
    a_tick_loaded: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.ftick |-> st_reg.clkdiv[7] ##1 !st_reg.ftick)
        else $error("timing tick wrong");
    a_win_high_map: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_valid && acc_addr[15:14] == 2'h3 |=> st_reg.arr_hit && st_reg.arr_addr[15:14] == 2'h3)
        else $error("high fixed window misplaced");
    a_page_map: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_valid && acc_addr[15:14] == 2'h2 && page_select == 8'h3C
        |=> st_reg.arr_hit && st_reg.arr_addr[15:14] == 2'h0)
        else $error("paged window misplaced");
    a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ph && !hwrite && haddr[31:6] == 26'h0 && haddr[5:2] == 4'h7
        |=> st_reg.rdata == 32'h0)
        else $error("reserved register read nonzero");
    a_low_region: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_valid && acc_addr[15:10] == 6'h10 && st_reg.prot[7] && !st_reg.prot[2]
        |=> st_reg.arr_prot)
        else $error("low region start not protected");
endmodule // fmp_top

// file: dv/fmp_cpu_model.sv
// cpu-side model: array accesses and the core page register
`timescale 1ns/1ps

module fmp_cpu_model (
    input wire logic hclk,
    input wire logic en,
    output logic acc_valid,
    output logic [15:0] acc_addr,
    output logic [7:0] page_select
);
    initial begin
        acc_valid = 1'b0;
        acc_addr = 16'h0000;
        page_select = 8'h3C;
    end
    // new random address every edge, so idle lines repeat the last access only by chance
    always @(posedge hclk) begin
        acc_valid <= en && ($urandom % 4 != 0);
        if ($urandom % 3 == 0) begin
            acc_addr <= {(($urandom % 3) == 0) ? 8'h40 : ((($urandom % 2) != 0) ? 8'hFF : 8'hBF),
                4'h0, 4'($urandom)};
        end else begin
            acc_addr <= 16'($urandom);
        end
        if ($urandom % 8 == 0) begin
            page_select <= 8'h3A + 8'($urandom % 6);
        end
    end
endmodule // fmp_cpu_model

// file: dv/fmp_top_tb.sv
// self-checking bench for the flash map, protection and divider front end
`timescale 1ns/1ps
`include "fmp_consts.svh"

module fmp_top_tb;
    localparam int OSC_HALF = 4;
    localparam logic [3:0] RSV [10] = '{4'h2, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, osc_clk, en, be, ad, loaded;
    logic acc_valid, arr_hit, arr_protected, key_area, cfg_area, flash_tick, cmd_start, p_valid;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] acc_addr, arr_addr, p_addr;
    logic [7:0] page_select, p_page, cfg_prot_byte, cfg_sec_byte, operation_command;
    logic [7:0] interrupt_and_key_config, security_state;
    logic [19:0] ex;
    logic [5:0] fld;
    logic pre;
    int mismatches, num_checks, oc, g, n;

    assign hready = hreadyout;

    fmp_top u_fmp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_clk(osc_clk),
        .page_select(page_select), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .cfg_prot_byte(cfg_prot_byte), .cfg_sec_byte(cfg_sec_byte), .buffer_empty_flag(be),
        .all_done_flag(ad), .viol_event(1'b0), .err_event(1'b0), .arr_addr(arr_addr),
        .arr_hit(arr_hit), .arr_protected(arr_protected), .key_area(key_area),
        .cfg_area(cfg_area), .flash_tick(flash_tick), .cmd_start(cmd_start),
        .operation_command(operation_command),
        .interrupt_and_key_config(interrupt_and_key_config), .security_state(security_state));

    fmp_cpu_model u_fmp_cpu_model (.hclk(hclk), .en(en), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .page_select(page_select));

    // ************************************************************
    // expectations and comparisons
    // ************************************************************
    function automatic logic [19:0] arr_exp(logic [15:0] a, logic [7:0] ps, logic [7:0] pr);
        logic [7:0] pg;
        logic [14:0] o;
        logic h;
        pg = (a[15:14] == 2'h1) ? 8'h3E : ((a[15:14] == 2'h3) ? 8'h3F : ps);
        h = (a[15:14] != 2'h0) && (pg[7:2] == 6'h0F);
        o = {1'b0, a[13:0]};
        return {h, h && (!pr[7] || (pg == 8'h3E && !pr[2] && o < (15'h0400 << pr[1:0]))
            || (pg == 8'h3F && !pr[5] && o >= 15'h4000 - (15'h0800 << pr[4:3]))),
            h && pg == 8'h3F && o >= 15'h3F00 && o <= 15'h3F07,
            h && pg == 8'h3F && (o == 15'h3F0D || o == 15'h3F0F), pg[1:0], a[13:0]};
    endfunction

    function automatic int exp_gap(logic p, logic [5:0] f);
        return (p ? 8 : 1) * (int'(f) + 1) * 2 * OSC_HALF;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ************************************************************
    // bus master
    // ************************************************************
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 64);
        if (hready !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `FMP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        bus(1'b1, {26'h0, i, 2'h0}, d);
    endtask

    task automatic rchk(input string nm, input logic [3:0] i, input logic [7:0] e,
                        input logic [7:0] m);
        bus(1'b0, {26'h0, i, 2'h0}, 8'h00);
        chk(nm, {24'h0, e}, rd & {24'hFFFFFF, m});
    endtask

    task automatic tick_gap();
        for (n = 0; n < 9000 && flash_tick !== 1'b1; n++) @(negedge hclk);
        @(negedge hclk);
        for (g = 1; g < 9000 && flash_tick !== 1'b1; g++) @(negedge hclk);
        if (g >= 9000) begin
            mismatches++;
            summarize();
        end
    endtask

    // ************************************************************
    // clocks and array port monitor
    // ************************************************************
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
        if (oc == OSC_HALF - 1) begin
            osc_clk <= ~osc_clk;
        end
    end

    always @(negedge hclk) begin
        ex = arr_exp(p_addr, p_page, cfg_prot_byte);
        chk("arr_hit", {31'h0, p_valid & ex[19]}, {31'h0, arr_hit});
        if (p_valid && ex[19]) begin
            chk("arr_addr", {16'h0, ex[15:0]}, {16'h0, arr_addr});
            chk("arr_protected", {31'h0, ex[18]}, {31'h0, arr_protected});
            chk("key_area", {31'h0, ex[17]}, {31'h0, key_area});
            chk("cfg_area", {31'h0, ex[16]}, {31'h0, cfg_area});
        end
        chk("tick_unloaded", 32'h0, {31'h0, flash_tick & ~loaded});
        chk("cmd_unloaded", 32'h0, {31'h0, cmd_start & ~loaded});
        p_valid = acc_valid;
        p_addr = acc_addr;
        p_page = page_select;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h55D82EC4));
        {hresetn, hsel, hwrite, osc_clk, en, be, ad, loaded, p_valid} = 9'h000;
        {haddr, hwdata, htrans, hsize, oc} = '0;
        {p_addr, p_page, cfg_prot_byte, cfg_sec_byte} = '0;
        for (int k = 0; k < 4; k++) begin
            @(posedge hclk);
            hresetn <= 1'b0;
            loaded = 1'b0;
            cfg_sec_byte <= {2'(k), 6'($urandom)};
            cfg_prot_byte <= 8'($urandom);
            {be, ad} <= 2'($urandom);
            repeat (3) @(posedge hclk);
            hresetn <= 1'b1;
            repeat (2) @(posedge hclk);
            rchk("security_state", `FMP_IDX_SEC, cfg_sec_byte, 8'hFF);
            wr(`FMP_IDX_SEC, ~cfg_sec_byte);
            rchk("security_ro", `FMP_IDX_SEC, cfg_sec_byte, 8'hFF);
            chk("security_port", {24'h0, cfg_sec_byte}, {24'h0, security_state});
            rchk("protection", `FMP_IDX_PROT, cfg_prot_byte, 8'hFF);
            rchk("divider_reset", `FMP_IDX_CLKDIV, 8'h00, 8'hFF);
            wr(`FMP_IDX_CNFG, 8'hFF);
            rchk("config", `FMP_IDX_CNFG, {2'h3, k == 2, 5'h00}, 8'hFF);
            wr(`FMP_IDX_CMD, 8'hFF);
            rchk("status_early", `FMP_IDX_STAT, {be, ad, 2'h1, 4'h0}, 8'hF0);
            chk("cmd_blocked", 32'h0, {24'h0, operation_command});
            foreach (RSV[i]) begin
                wr(RSV[i], 8'hFF);
                rchk("reserved", RSV[i], 8'h00, 8'hFF);
            end
            bus(1'b1, 32'h0000_0040, 8'hFF);
            bus(1'b0, 32'h0000_0040, 8'h00);
            chk("unmapped", 32'h0, rd);
            // odd passes prescale; k 1 the largest ratio, k 3 a legal 156 kHz rate
            pre = k[0];
            fld = (k == 1) ? 6'h3F : ((k == 3) ? 6'h13 : 6'($urandom % 8));
            wr(`FMP_IDX_CLKDIV, {1'b0, pre, fld});
            loaded = 1'b1;
            rchk("divider_first", `FMP_IDX_CLKDIV, {1'b1, pre, fld}, 8'hFF);
            wr(`FMP_IDX_CLKDIV, {1'b1, ~pre, ~fld});
            rchk("divider_once", `FMP_IDX_CLKDIV, {1'b1, pre, fld}, 8'hFF);
            tick_gap();
            chk("tick_period", exp_gap(pre, fld), g);
            wr(`FMP_IDX_CMD, 8'hFF);
            for (n = 0; n < 8 && cmd_start !== 1'b1; n++) @(negedge hclk);
            chk("cmd_start", 32'h1, {31'h0, cmd_start});
            chk("command", {24'h0, 8'h65}, {24'h0, operation_command});
            @(posedge hclk);
            en <= 1'b1;
            repeat (300) @(posedge hclk);
            en <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        summarize();
    end
endmodule // fmp_top_tb
